/* hw/dma_engine.sv */
// Purpose: four channel dma engine with separate read and write masters
// Assumes: one clock, synchronous active high reset, triggers on same clock
// Notes:   one byte in flight; channels are re-arbitrated between bursts
//
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/100ps

module dma_engine
    import dma_pkg::*;
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // wishbone register slave
    input  wire logic          wb_cyc,
    input  wire logic          wb_stb,
    input  wire logic          wb_we,
    input  wire logic [7:0]    wb_adr,
    input  wire logic [3:0]    wb_sel,
    input  wire logic [31:0]   wb_dat_w,
    output logic      [31:0]   wb_dat_r,
    output logic               wb_ack,
    // channel triggers
    input  wire logic [NCH-1:0] periph_req,
    input  wire logic [NCH-1:0] event_trig,
    // read master
    output logic               rd_stb,
    output logic      [AW-1:0] rd_addr,
    input  wire logic [7:0]    rd_data,
    input  wire logic          rd_ext_ack,
    input  wire logic          rd_err,
    // write master
    output logic               wr_stb,
    output logic      [AW-1:0] wr_addr,
    output logic      [7:0]    wr_data,
    input  wire logic          wr_ext_ack,
    input  wire logic          wr_err,
    // interrupt
    output logic               irq
);

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [1:0] region(input logic [AW-1:0] a);
        if (a >= EXT_BASE) return RG_EXT;
        if (a >= SRAM_BASE) return RG_SRAM;
        if (a >= EE_BASE) return RG_EE;
        return RG_IO;
    endfunction

    // read latency; an sram or eeprom byte that continues a burst streams faster
    function automatic logic [1:0] rd_lat(input logic [1:0] rg, input logic cont);
        case (rg)
            RG_SRAM: rd_lat = cont ? LAT_SRAM_BRD : LAT_SRAM_RD;
            RG_EE:   rd_lat = cont ? LAT_EE_BRD : LAT_EE_RD;
            default: rd_lat = LAT_IO;
        endcase
    endfunction

    function automatic logic [AW-1:0] step(input logic [AW-1:0] a, input logic [1:0] m);
        case (m)
            AM_INC:  step = a + 24'h000001;
            AM_DEC:  step = a - 24'h000001;
            default: step = a;
        endcase
    endfunction

    // pick a pending channel: fixed order from channel 0, or round robin
    function automatic logic [1:0] pick(input logic [NCH-1:0] req, input logic [1:0] last,
                                        input logic rr);
        logic [1:0] idx;
        logic [1:0] res;
        logic       hit;
        res = 2'h0;
        hit = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            idx = rr ? 2'(last + 2'(i + 1)) : 2'(i);
            if (!hit && req[idx]) begin
                res = idx;
                hit = 1'b1;
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state
    state_e                st_q;
    logic [NCH-1:0]        en_q, pend_q, inblk_q;
    logic [1:0]            burst_q [NCH];
    logic [NCH-1:0]        rep_en_q, link_q;
    logic [1:0]            trig_q  [NCH];
    logic [7:0]            actl_q  [NCH];
    logic [15:0]           blk_q   [NCH];
    logic [15:0]           brem_q  [NCH];
    logic [7:0]            rep_q   [NCH];
    logic [7:0]            rrem_q  [NCH];
    logic [AW-1:0]         src_q   [NCH];
    logic [AW-1:0]         src0_q  [NCH];
    logic [AW-1:0]         dst_q   [NCH];
    logic [AW-1:0]         dst0_q  [NCH];
    logic                  gen_q, grr_q;
    logic [7:0]            ist_q, ien_q;
    logic [1:0]            act_q, last_q;
    logic [2:0]            bcnt_q;
    logic [1:0]            wait_q;
    logic                  ext_q;

    ////////////////////////////////////////////////////////////////////////
    // register decode
    logic        acc, wr_acc, glb, sw_hit;
    logic [1:0]  wch;
    logic [2:0]  wreg;
    logic [31:0] ctrl_w, ac_w, ch_word, glb_word, rword;
    assign acc    = wb_cyc && wb_stb && !wb_ack;
    assign wr_acc = acc && wb_we;
    assign glb    = wb_adr[7];
    assign wch    = wb_adr[6:5];
    assign wreg   = wb_adr[4:2];
    assign ctrl_w = merge({23'h0, inblk_q[wch] | pend_q[wch], link_q[wch], trig_q[wch],
                           rep_en_q[wch], burst_q[wch], pend_q[wch], en_q[wch]},
                          wb_dat_w, wb_sel);
    assign ac_w   = merge({24'h0, actl_q[wch]}, wb_dat_w, wb_sel);
    assign sw_hit = wr_acc && !glb && wreg == REG_CTRL && ctrl_w[CTRL_SWTRIG];

    // read mux; unmapped words answer zero
    assign ch_word = (wreg == REG_CTRL)     ? {ctrl_w[31:9] & 23'h0,
                                               inblk_q[wch] | pend_q[wch], link_q[wch],
                                               trig_q[wch], rep_en_q[wch], burst_q[wch],
                                               pend_q[wch], en_q[wch]} :
                     (wreg == REG_ADDRCTRL) ? {24'h0, actl_q[wch]} :
                     (wreg == REG_BLKCNT)   ? {16'h0, blk_q[wch]} :
                     (wreg == REG_REPCNT)   ? {24'h0, rep_q[wch]} :
                     (wreg == REG_SRCADDR)  ? {8'h0, src_q[wch]} :
                     (wreg == REG_DSTADDR)  ? {8'h0, dst_q[wch]} : 32'h0;
    assign glb_word = (wb_adr == A_GCTRL)   ? {30'h0, grr_q, gen_q} :
                      (wb_adr == A_INTSTAT) ? {24'h0, ist_q} :
                      (wb_adr == A_INTEN)   ? {24'h0, ien_q} : 32'h0;
    assign rword    = glb ? glb_word : ch_word;

    ////////////////////////////////////////////////////////////////////////
    // triggers and arbitration
    logic [NCH-1:0] trig_hit, cand;
    logic [1:0]     win;
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_trig
            // a software trigger may ride on the very write that enables
            assign trig_hit[g] = (sw_hit && wch == 2'(g) && ctrl_w[CTRL_EN]) ||
                (en_q[g] && trig_q[g] == TS_PERIPH && periph_req[g]) ||
                (en_q[g] && trig_q[g] == TS_EVENT && event_trig[g]);
        end
    endgenerate
    assign cand = pend_q & en_q;
    assign win  = pick(cand, last_q, grr_q);

    ////////////////////////////////////////////////////////////////////////
    // active channel view
    logic [AW-1:0] nsrc, ndst;
    logic [3:0]    blen;
    logic          last_burst, last_blk, last_trans, xfer_err, rd_done, wr_done;
    logic          rl_src, rl_dst;
    logic [1:0]    srl, drl;
    assign nsrc       = step(src_q[act_q], actl_q[act_q][AC_SRCMODE +: 2]);
    assign ndst       = step(dst_q[act_q], actl_q[act_q][AC_DSTMODE +: 2]);
    assign blen       = 4'h1 << burst_q[act_q];
    assign last_blk   = brem_q[act_q] == 16'h0001;
    assign last_burst = (4'({1'b0, bcnt_q}) == blen - 4'h1) || last_blk;
    assign last_trans = last_blk && (!rep_en_q[act_q] || rrem_q[act_q] == 8'h01);
    assign srl        = actl_q[act_q][AC_SRCRL +: 2];
    assign drl        = actl_q[act_q][AC_DSTRL +: 2];
    // a block end is also a burst end, a transaction end also a block end
    assign rl_src = (srl == RL_BURST && last_burst) || (srl == RL_BLOCK && last_blk) ||
                    (srl == RL_TRANS && last_trans);
    assign rl_dst = (drl == RL_BURST && last_burst) || (drl == RL_BLOCK && last_blk) ||
                    (drl == RL_TRANS && last_trans);
    // external memory has no fixed count, so it finishes on its own answer
    assign rd_done  = ext_q ? rd_ext_ack : (wait_q == 2'h0);
    assign wr_done  = ext_q ? wr_ext_ack : (wait_q == 2'h0);
    assign xfer_err = wr_done && wr_err;

    ////////////////////////////////////////////////////////////////////////
    // wishbone answer and interrupt
    logic [7:0] ev_set;
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack   <= 1'b0;
            wb_dat_r <= 32'h0;
            irq      <= 1'b0;
        end else begin
            wb_ack   <= acc;              // one wait state, every address answers
            wb_dat_r <= (acc && !wb_we) ? rword : 32'h0;
            irq      <= |(ist_q & ien_q);
        end
    end

    // status: set wins over a clear written in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            ist_q <= 8'h0;
            ien_q <= 8'h0;
            gen_q <= 1'b0;
            grr_q <= 1'b0;
        end else begin
            if (wr_acc && wb_adr == A_GCTRL) begin
                {grr_q, gen_q} <= 2'(merge({30'h0, grr_q, gen_q}, wb_dat_w, wb_sel));
            end
            if (wr_acc && wb_adr == A_INTEN) begin
                ien_q <= 8'(merge({24'h0, ien_q}, wb_dat_w, wb_sel));
            end
            ist_q <= ((wr_acc && wb_adr == A_INTCLR && wb_sel[0]) ? ist_q & ~wb_dat_w[7:0]
                                                                 : ist_q) | ev_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // channel registers and transfer engine
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q    <= ST_IDLE;
            en_q    <= '0;
            pend_q  <= '0;
            inblk_q <= '0;
            rep_en_q <= '0;
            link_q  <= '0;
            act_q   <= 2'h0;
            last_q  <= 2'h3;
            bcnt_q  <= 3'h0;
            wait_q  <= 2'h0;
            ext_q   <= 1'b0;
            ev_set  <= 8'h0;
            rd_stb  <= 1'b0;
            rd_addr <= '0;
            wr_stb  <= 1'b0;
            wr_addr <= '0;
            wr_data <= 8'h0;
            for (int i = 0; i < NCH; i++) begin
                burst_q[i] <= 2'h0;
                trig_q[i]  <= TS_SW;
                actl_q[i]  <= 8'h0;
                blk_q[i]   <= 16'h0;
                brem_q[i]  <= 16'h0;
                rep_q[i]   <= 8'h0;
                rrem_q[i]  <= 8'h0;
                src_q[i]   <= '0;
                src0_q[i]  <= '0;
                dst_q[i]   <= '0;
                dst0_q[i]  <= '0;
            end
        end else begin
            ev_set <= 8'h0;
            // software settings, held per channel
            if (wr_acc && !glb) begin
                case (wreg)
                    REG_CTRL: begin
                        en_q[wch]     <= ctrl_w[CTRL_EN];
                        burst_q[wch]  <= ctrl_w[CTRL_BURST +: 2];
                        rep_en_q[wch] <= ctrl_w[CTRL_REPEAT];
                        trig_q[wch]   <= ctrl_w[CTRL_TRIG +: 2];
                        link_q[wch]   <= ctrl_w[CTRL_LINK];
                        if (ctrl_w[CTRL_EN] && !en_q[wch]) begin
                            rrem_q[wch] <= rep_q[wch];
                        end
                    end
                    REG_ADDRCTRL: actl_q[wch] <= ac_w[7:0];
                    REG_BLKCNT:   blk_q[wch] <= 16'(merge({16'h0, blk_q[wch]}, wb_dat_w, wb_sel));
                    REG_REPCNT:   rep_q[wch] <= 8'(merge({24'h0, rep_q[wch]}, wb_dat_w, wb_sel));
                    REG_SRCADDR: begin
                        src_q[wch]  <= AW'(merge({8'h0, src_q[wch]}, wb_dat_w, wb_sel));
                        src0_q[wch] <= AW'(merge({8'h0, src_q[wch]}, wb_dat_w, wb_sel));
                    end
                    REG_DSTADDR: begin
                        dst_q[wch]  <= AW'(merge({8'h0, dst_q[wch]}, wb_dat_w, wb_sel));
                        dst0_q[wch] <= AW'(merge({8'h0, dst_q[wch]}, wb_dat_w, wb_sel));
                    end
                    default: ;
                endcase
            end
            pend_q <= pend_q | trig_hit;
            case (st_q)
                ST_IDLE: begin
                    if (gen_q && |cand) begin
                        act_q  <= win;
                        last_q <= win;
                        if (!inblk_q[win]) begin
                            brem_q[win]  <= blk_q[win];  // zero wraps to a full 64KB
                            inblk_q[win] <= 1'b1;
                        end
                        bcnt_q  <= 3'h0;
                        rd_stb  <= 1'b1;
                        rd_addr <= src_q[win];
                        ext_q   <= region(src_q[win]) == RG_EXT;
                        wait_q  <= rd_lat(region(src_q[win]), 1'b0) - 2'h1;
                        st_q    <= ST_READ;
                    end
                end
                ST_READ: begin
                    if (rd_done) begin
                        rd_stb <= 1'b0;
                        if (rd_err) begin
                            // a failed read never reaches the write side
                            en_q[act_q]    <= 1'b0;
                            pend_q[act_q]  <= 1'b0;
                            inblk_q[act_q] <= 1'b0;
                            ev_set[IS_ERR + 32'(act_q)] <= 1'b1;
                            st_q <= ST_IDLE;
                        end else begin
                            // any region may be written, eeprom loads its page buffer
                            wr_stb  <= 1'b1;
                            wr_addr <= dst_q[act_q];
                            wr_data <= rd_data;
                            ext_q   <= region(dst_q[act_q]) == RG_EXT;
                            wait_q  <= LAT_WR - 2'h1;
                            st_q    <= ST_WRITE;
                        end
                    end else if (!ext_q) begin
                        wait_q <= wait_q - 2'h1;
                    end
                end
                ST_WRITE: begin
                    if (wr_done) begin
                        wr_stb <= 1'b0;
                        src_q[act_q]  <= rl_src ? src0_q[act_q] : nsrc;
                        dst_q[act_q]  <= rl_dst ? dst0_q[act_q] : ndst;
                        brem_q[act_q] <= brem_q[act_q] - 16'h0001;
                        bcnt_q        <= bcnt_q + 3'h1;
                        if (xfer_err) begin
                            en_q[act_q]    <= 1'b0;
                            pend_q[act_q]  <= 1'b0;
                            inblk_q[act_q] <= 1'b0;
                            ev_set[IS_ERR + 32'(act_q)] <= 1'b1;
                            st_q <= ST_IDLE;
                        end else if (!last_burst) begin
                            // next byte of the burst streams at burst speed
                            rd_stb  <= 1'b1;
                            rd_addr <= nsrc;
                            ext_q   <= region(nsrc) == RG_EXT;
                            wait_q  <= rd_lat(region(nsrc), 1'b1) - 2'h1;
                            st_q    <= ST_READ;
                        end else begin
                            // burst over: hand the bus back to arbitration
                            st_q <= ST_IDLE;
                            if (last_blk) begin
                                pend_q[act_q]  <= 1'b0;  // next block needs a new trigger
                                inblk_q[act_q] <= 1'b0;
                                rrem_q[act_q]  <= rrem_q[act_q] - 8'h01;
                            end
                            if (last_trans) begin
                                en_q[act_q]          <= 1'b0;
                                ev_set[32'(act_q)]   <= 1'b1;
                                if (link_q[act_q]) begin
                                    // partner is enabled with its repeat count reloaded; it still waits for its own trigger
                                    en_q[act_q ^ 2'h1]   <= 1'b1;
                                    rrem_q[act_q ^ 2'h1] <= rep_q[act_q ^ 2'h1];
                                end
                            end
                        end
                    end else if (!ext_q) begin
                        wait_q <= wait_q - 2'h1;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

endmodule

/* hw/dma_pkg.sv */
// Purpose: shared constants for the four channel dma engine
// Assumes: 32-bit classic wishbone register port, byte wide data path
// Notes:   register map, field positions, address regions and access timing
package dma_pkg;

    localparam int NCH = 4;   // channel count
    localparam int AW  = 24;  // data memory address width

    // per-channel register words: byte address = ch*0x20 + index*4
    localparam logic [2:0] REG_CTRL     = 3'h0;
    localparam logic [2:0] REG_ADDRCTRL = 3'h1;
    localparam logic [2:0] REG_BLKCNT   = 3'h2;
    localparam logic [2:0] REG_REPCNT   = 3'h3;
    localparam logic [2:0] REG_SRCADDR  = 3'h4;
    localparam logic [2:0] REG_DSTADDR  = 3'h5;

    // global registers
    localparam logic [7:0] A_GCTRL   = 8'h80;
    localparam logic [7:0] A_INTSTAT = 8'h84;
    localparam logic [7:0] A_INTCLR  = 8'h88;
    localparam logic [7:0] A_INTEN   = 8'h8c;

    // channel control fields
    localparam int CTRL_EN     = 0;
    localparam int CTRL_SWTRIG = 1;
    localparam int CTRL_BURST  = 2;  // two bits
    localparam int CTRL_REPEAT = 4;
    localparam int CTRL_TRIG   = 5;  // two bits
    localparam int CTRL_LINK   = 7;
    localparam int CTRL_BUSY   = 8;
    // address control fields, two bits each
    localparam int AC_SRCMODE = 0;
    localparam int AC_SRCRL   = 2;
    localparam int AC_DSTMODE = 4;
    localparam int AC_DSTRL   = 6;
    // global control fields
    localparam int GC_EN = 0;
    localparam int GC_RR = 1;
    // interrupt status layout: done in [3:0], error in [7:4]
    localparam int IS_ERR = 4;

    localparam logic [1:0] AM_FIXED = 2'h0;
    localparam logic [1:0] AM_INC   = 2'h1;
    localparam logic [1:0] AM_DEC   = 2'h2;

    localparam logic [1:0] RL_NONE  = 2'h0;
    localparam logic [1:0] RL_BLOCK = 2'h1;
    localparam logic [1:0] RL_BURST = 2'h2;
    localparam logic [1:0] RL_TRANS = 2'h3;

    localparam logic [1:0] TS_SW     = 2'h0;
    localparam logic [1:0] TS_PERIPH = 2'h1;
    localparam logic [1:0] TS_EVENT  = 2'h2;

    // data memory regions
    localparam logic [AW-1:0] EE_BASE   = 24'h001000;
    localparam logic [AW-1:0] SRAM_BASE = 24'h002000;
    localparam logic [AW-1:0] EXT_BASE  = 24'h004000;
    localparam logic [1:0] RG_IO   = 2'h0;
    localparam logic [1:0] RG_EE   = 2'h1;
    localparam logic [1:0] RG_SRAM = 2'h2;
    localparam logic [1:0] RG_EXT  = 2'h3;

    // access timing in clock cycles
    localparam logic [1:0] LAT_IO       = 2'h1;
    localparam logic [1:0] LAT_SRAM_RD  = 2'h2;
    localparam logic [1:0] LAT_SRAM_BRD = 2'h1;
    localparam logic [1:0] LAT_EE_RD    = 2'h3;
    localparam logic [1:0] LAT_EE_BRD   = 2'h2;
    localparam logic [1:0] LAT_WR       = 2'h1;

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} state_e;

endpackage

/* verification/dma_engine_sva.sv */
// Purpose: port assertions for dma_engine
// Assumes: one clock, synchronous reset
// Notes:   region bounds from package constants; access cycle counts written into the sequences
`timescale 1ns/100ps
module dma_engine_sva
    import dma_pkg::*;
(
    // clock and reset
    input wire logic          clk,
    input wire logic          rst,
    // register bus
    input wire logic          wb_cyc,
    input wire logic          wb_stb,
    input wire logic          wb_ack,
    input wire logic [31:0]   wb_dat_r,
    // memory masters
    input wire logic          rd_stb,
    input wire logic [AW-1:0] rd_addr,
    input wire logic          rd_ext_ack,
    input wire logic          wr_stb,
    input wire logic [AW-1:0] wr_addr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    //////////////////////////////
    // region decode of the read address
    wire sram_a = rd_addr >= SRAM_BASE && rd_addr < EXT_BASE;
    wire ee_a   = rd_addr >= EE_BASE && rd_addr < SRAM_BASE;
    // a read after an idle cycle opens a burst; later reads stream
    sequence s_open;
        $rose(rd_stb) && !$past(wr_stb);
    endsequence
    sequence s_sram2;
        rd_stb [*2] ##1 (wr_stb && !rd_stb);
    endsequence
    sequence s_ee3;
        rd_stb [*3] ##1 (wr_stb && !rd_stb);
    endsequence
    //////////////////////////////
    AST_WB_ACK: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
        else $error("register access not answered next cycle");
    AST_ACK_PULSE: assert property (wb_ack |=> !wb_ack)
        else $error("ack longer than one cycle");
    AST_DAT_IDLE: assert property (!wb_ack |-> wb_dat_r == 32'h0)
        else $error("read data outside ack");
    AST_INT_WR: assert property (wr_stb && wr_addr < EXT_BASE |=> !wr_stb)
        else $error("internal write longer than one cycle");
    AST_SRAM_RD: assert property (sram_a ##0 s_open |-> s_sram2)
        else $error("sram read not two cycles");
    AST_SRAM_BURST: assert property (sram_a && $rose(rd_stb) && $past(wr_stb) |=> wr_stb)
        else $error("sram burst byte not every cycle");
    AST_EE_RD: assert property (ee_a ##0 s_open |-> s_ee3)
        else $error("eeprom read not three cycles");
    AST_EXT_HOLD: assert property (rd_stb && rd_addr >= EXT_BASE && !rd_ext_ack |=>
        rd_stb && $stable(rd_addr))
        else $error("external read dropped before its answer");
    AST_ONE_BYTE: assert property (rd_stb |-> !wr_stb)
        else $error("read and write strobes together");
endmodule
bind dma_engine dma_engine_sva i_dma_engine_sva (.clk, .rst, .wb_cyc, .wb_stb, .wb_ack,
    .wb_dat_r, .rd_stb, .rd_addr, .rd_ext_ack, .wr_stb, .wr_addr);

/* verification/mem_model.sv */
// Purpose: data memory model facing the engine's masters
// Assumes: byte pattern derived from the read address
// Notes:   external reads answer after slow cycles; error only on command
`timescale 1ns/100ps
module mem_model
    import dma_pkg::*;
(
    // clock and test control
    input  wire logic          clk,
    input  wire logic [3:0]    slow,
    input  wire logic          err_cmd,
    // read master
    input  wire logic          rd_stb,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [7:0]    rd_data,
    output logic               rd_ext_ack,
    output logic               rd_err,
    // write master
    input  wire logic          wr_stb,
    input  wire logic [AW-1:0] wr_addr,
    output logic               wr_ext_ack,
    output logic               wr_err
);
    logic [3:0] wait_q = 4'h0;
    logic [7:0] last_q = 8'h00;
    wire        ext_rd = rd_stb && rd_addr >= EXT_BASE;
    // released data lines show the inverse first, then toggle, so a sample one cycle late never matches
    assign rd_data    = rd_stb ? rd_addr[7:0] ^ 8'h5a : ~last_q;
    assign rd_ext_ack = ext_rd && wait_q >= slow;
    assign rd_err     = rd_ext_ack && err_cmd;
    assign wr_ext_ack = wr_stb && wr_addr >= EXT_BASE;
    assign wr_err     = 1'b0;
    // wait count restarts for every external read
    always @(posedge clk) begin
        wait_q <= ext_rd && !rd_ext_ack ? wait_q + 4'h1 : 4'h0;
        last_q <= rd_data;
    end
endmodule

/* verification/tb_top.sv */
// Purpose: self-checking bench for dma_engine
// Assumes: mem_model on both masters
// Notes:   writes are logged as {address, data}
`timescale 1ns/100ps
module tb_top
    import dma_pkg::*;
;
    logic          clk = 1'b0, rst = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic          err_cmd = 1'b0, wb_ack, rd_ext_ack, rd_err, wr_ext_ack, wr_err, irq;
    logic          rd_stb, wr_stb;
    logic [7:0]    wb_adr = 8'h00, rd_data, wr_data;
    logic [3:0]    wb_sel = 4'hf, slow = 4'h3, periph_req = 4'h0, event_trig = 4'h0;
    logic [31:0]   wb_dat_w = 32'h0, wb_dat_r, rd_q, wlog[$];
    logic [AW-1:0] rd_addr, wr_addr;
    int            err_total = 0, n_checks = 0, cyc_n = 0;
    always #5 clk = ~clk;
    dma_engine i_dma_engine (.*);
    mem_model  i_mem_model (.*);
    // log completed writes; timeout ends a hang
    always @(posedge clk) begin
        if (wr_stb && (wr_addr < EXT_BASE || wr_ext_ack)) wlog.push_back({wr_addr, wr_data});
        cyc_n++;
        if (cyc_n == 20000) begin
            err_total++;
            close_out();
        end
    end
    //////////////////////////////
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    // one classic cycle; ack and data taken at the same edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} <= {2'b11, w, a, d};
        for (int n = 0; n < 20 && wb_ack !== 1'b1; n++) @(posedge clk);
        rd_q = wb_dat_r;
        {wb_cyc, wb_stb} <= 2'b00;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(nm, e, rd_q);
    endtask
    task automatic wait_bit(input int b);
        for (int n = 0; n < 200 && rd_q[b] !== 1'b1; n++) wb(1'b0, A_INTSTAT, 32'h0);
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(posedge clk);
        chk("irq", e, irq);
    endtask
    //////////////////////////////
    task automatic t_reset();
        rchk("intstat", A_INTSTAT, 32'h0);
        rchk("unmapped", 8'h9c, 32'h0);
        wb(1'b1, 8'h30, 32'h00abcdef);
        rchk("src1", 8'h30, 32'h00abcdef);
        rchk("src0", 8'h10, 32'h0);
    endtask
    // sram to io, 2 byte bursts, source reloaded after each burst
    task automatic t_copy();
        wb(1'b1, 8'h10, 32'h2010);
        wb(1'b1, 8'h14, 32'h40);
        wb(1'b1, 8'h04, 32'h09);
        wb(1'b1, 8'h08, 32'h4);
        wb(1'b1, A_INTEN, 32'h1);
        wb(1'b1, A_GCTRL, 32'h1);
        wb(1'b1, 8'h00, 32'h07);
        wait_bit(0);
        for (int i = 0; i < 4; i++) chk("wr", {24'h40, {7'h08, i[0]} ^ 8'h5a}, wlog[i]);
        chk("nwr", 4, wlog.size());
        irq_is(1'b1);
        wb(1'b1, A_INTCLR, 32'h1);
        rchk("clr", A_INTSTAT, 32'h0);
        irq_is(1'b0);
        wlog.delete();
    endtask
    // eeprom down to sram up, peripheral trigger, irq masked
    task automatic t_ee();
        wb(1'b1, 8'h30, 32'h1005);
        wb(1'b1, 8'h34, 32'h2100);
        wb(1'b1, 8'h24, 32'h12);
        wb(1'b1, 8'h28, 32'h4);
        wb(1'b1, 8'h20, 32'h25);
        periph_req <= 4'h2;
        @(posedge clk);
        periph_req <= 4'h0;
        wait_bit(1);
        for (int i = 0; i < 4; i++) chk("ee", {24'(24'h2100 + i), 8'(8'h05 - i) ^ 8'h5a},
            wlog[i]);
        irq_is(1'b0);
        wb(1'b1, A_INTCLR, 32'h2);
        wlog.delete();
    endtask
    // two-block repeat on channel 0, linked to channel 1
    task automatic t_link();
        wb(1'b1, 8'h0c, 32'h2);
        wb(1'b1, 8'h00, 32'h97);
        repeat (40) @(posedge clk);
        wb(1'b1, 8'h00, 32'h97);
        wait_bit(0);
        chk("nrep", 8, wlog.size());
        rchk("link", 8'h20, 32'h25);
        rchk("ch0", 8'h00, 32'h94);
        wb(1'b1, A_INTCLR, 32'h1);
        wlog.delete();
    endtask
    // external read answered with an error, event trigger
    task automatic t_err();
        wb(1'b1, 8'h50, 32'h4000);
        wb(1'b1, 8'h48, 32'h1);
        wb(1'b1, A_INTEN, 32'h40);
        wb(1'b1, 8'h40, 32'h41);
        err_cmd <= 1'b1;
        event_trig <= 4'h4;
        @(posedge clk);
        event_trig <= 4'h0;
        wait_bit(6);
        irq_is(1'b1);
        rchk("stopped", 8'h40, 32'h40);
        chk("nowr", 0, wlog.size());
        rchk("sticky", A_INTSTAT, 32'h40);
        wb(1'b1, A_INTCLR, 32'h40);
        rchk("errclr", A_INTSTAT, 32'h0);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_copy();
        t_ee();
        t_link();
        t_err();
        close_out();
    end
endmodule
